// ==== rpv_pkg.sv ====
// Functional notes
// - Custom length bit picks 16 or 20 bits.
// - Length field decodes to PRBS7/11/23/31/15/20.
// - Pattern select: off, PRBS, clock, custom, timing.
// - Custom word from bytes; top nibble if 20.
// - Deskew-complete status bit reads alignment done.
// - Error counter zeroes on clear-bit rising edge.
// - Latched-flag clear bit clears latched flags.
// - Three-bit field selects test interrupt source.
// - Per-lane datapath check enable bits.
// - Datapath source drives lane-0 count and flags.
// - Latched lane flags read in bits 7:4.
// - Live lane flags read in bits 3:0.
// - Lane-0 error count low byte readable.
// - Load bit passes controls; falling edge holds.
// - Per-lane pattern mismatch status bit.
// - Per-lane search in progress status bit.
package rpv_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_LOAD   = 8'h0e;
  localparam logic [7:0] ADDR_STAT   = 8'h0f;
  localparam logic [7:0] ADDR_CFG    = 8'h10;
  localparam logic [7:0] ADDR_CP_LO  = 8'h11;
  localparam logic [7:0] ADDR_CP_MID = 8'h12;
  localparam logic [7:0] ADDR_CP_HI  = 8'h13;
  localparam logic [7:0] ADDR_THR    = 8'h14;
  localparam logic [7:0] ADDR_CLRSEL = 8'h15;
  localparam logic [7:0] ADDR_DPCTL  = 8'h16;
  localparam logic [7:0] ADDR_FLAGS  = 8'h17;
  localparam logic [7:0] ADDR_CNT_LO = 8'h18;
  // Reset value shared by every register.
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  // Field positions.
  localparam int CFG_CP20_BIT  = 7;
  localparam int CFG_LEN_LSB   = 3;
  localparam int CFG_SEL_LSB   = 0;
  localparam int CLR_ALIGN_BIT = 7;
  localparam int CLR_CNT_BIT   = 4;
  localparam int CLR_FLAG_BIT  = 3;
  localparam int DP_EN_LSB     = 4;
  // Sizes and timing counts, in received bits.
  localparam int NUM_LANES     = 4;
  localparam int CNT_W         = 12;
  localparam logic [5:0] LOCK_RUN = 6'h20;
  localparam logic [4:0] CLOCK_HALF   = 5'h05;
  localparam logic [4:0] CLOCK_PERIOD = 5'h0a;
  localparam logic [4:0] CUSTOM_SHORT = 5'h10;
  localparam logic [4:0] CUSTOM_LONG  = 5'h14;
  // Pattern select codes; any code with bit 2 set is timing only.
  localparam logic [2:0] SEL_OFF    = 3'h0;
  localparam logic [2:0] SEL_PRBS   = 3'h1;
  localparam logic [2:0] SEL_CLOCK  = 3'h2;
  localparam logic [2:0] SEL_CUSTOM = 3'h3;
  // Datapath source codes.
  localparam logic [2:0] DP_DISP  = 3'h0;
  localparam logic [2:0] DP_FIFO  = 3'h1;
  localparam logic [2:0] DP_OVF   = 3'h2;
  localparam logic [2:0] DP_UNF   = 3'h3;
  localparam logic [2:0] DP_ALIGN = 3'h4;
  // Interrupt source codes.
  localparam logic [2:0] IRQ_MISS   = 3'h0;
  localparam logic [2:0] IRQ_SEARCH = 3'h1;
  localparam logic [2:0] IRQ_SYNC   = 3'h2;
  // Checker states.
  typedef enum logic [1:0] {CHK_IDLE, CHK_SEARCH, CHK_LOCK} rpv_chk_state_t;
  // Generator order and feedback tap for a length code.
  function automatic logic [9:0] prbs_taps(input logic [2:0] len);
    case (len)
      3'h0: prbs_taps = {5'd7, 5'd6};
      3'h1: prbs_taps = {5'd11, 5'd9};
      3'h2: prbs_taps = {5'd23, 5'd18};
      3'h3: prbs_taps = {5'd31, 5'd28};
      3'h4, 3'h5: prbs_taps = {5'd15, 5'd14};
      default: prbs_taps = {5'd20, 5'd3};
    endcase
  endfunction
endpackage

// ==== rpv_lane_latch.sv ====
`timescale 1ns/100ps
// Transparent-while-loading holding latch for one lane's controls.
module rpv_lane_latch #(
  parameter int W = 30
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // Control word in and load strobe.
  input  wire logic         load_i,
  input  wire logic [W-1:0] d_i,
  // Control word seen by the lane.
  output logic      [W-1:0] q_o
);
  logic [W-1:0] held;  // Value captured while loading.

  // Keep tracking while load is high so the last value stays on release.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      held <= '0;
    end else if (load_i) begin
      held <= d_i;
    end
  end

  // Pass straight through while loading; otherwise show the held copy.
  assign q_o = load_i ? d_i : held;
endmodule

// ==== rpv_lane_check.sv ====
`timescale 1ns/100ps
// One lane's pattern checker: PRBS self-sync, clock and custom compare.
module rpv_lane_check (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Received bit stream.
  input  wire logic        bit_valid_i,
  input  wire logic        bit_i,
  // Latched controls.
  input  wire logic [2:0]  sel_i,
  input  wire logic [2:0]  len_i,
  input  wire logic        cp20_i,
  input  wire logic [19:0] pattern_i,
  input  wire logic [2:0]  thr_i,
  // Results.
  output logic             err_o,
  output logic             mismatch_o,
  output logic             search_o,
  output logic             sync_o
);
  rpv_pkg::rpv_chk_state_t state;  // Checker state.
  logic [30:0] hist;                // Past received bits, newest at 0.
  logic [4:0]  idx;                 // Phase in clock or custom pattern.
  logic [5:0]  run;                 // Consecutive good bits while searching.
  logic [2:0]  bad;                 // Consecutive bad bits while locked.
  logic [30:0] sync_cnt;            // Bits since last timing pulse.
  logic [9:0]  taps;
  logic [4:0]  period;
  logic        expect_bit;
  logic        miss;

  assign taps = rpv_pkg::prbs_taps(len_i);
  // Custom period follows the length bit; clock pattern is fixed.
  assign period = (sel_i == rpv_pkg::SEL_CLOCK) ? rpv_pkg::CLOCK_PERIOD :
                  (cp20_i ? rpv_pkg::CUSTOM_LONG : rpv_pkg::CUSTOM_SHORT);

  // Expected bit for the current mode.
  always_comb begin
    case (sel_i)
      rpv_pkg::SEL_PRBS:   expect_bit = hist[taps[9:5] - 5'd1] ^ hist[taps[4:0] - 5'd1];
      rpv_pkg::SEL_CLOCK:  expect_bit = (idx < rpv_pkg::CLOCK_HALF);
      rpv_pkg::SEL_CUSTOM: expect_bit = pattern_i[idx];
      default:             expect_bit = bit_i;  // Off and timing modes never miss.
    endcase
  end
  assign miss = bit_valid_i && (bit_i != expect_bit);

  // History shift register.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hist <= '0;
    end else if (bit_valid_i) begin
      hist <= {hist[29:0], bit_i};
    end
  end

  // Phase counter; a miss while searching holds it, slipping one bit.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      idx <= '0;
    end else if (bit_valid_i && !(miss && state == rpv_pkg::CHK_SEARCH)) begin
      idx <= (idx >= period - 5'd1) ? 5'd0 : idx + 5'd1;
    end
  end

  // Search, lock and loss of lock.  Loss needs more than thr_i bad bits in a row.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= rpv_pkg::CHK_IDLE;
      run   <= '0;
      bad   <= '0;
    end else if (sel_i == rpv_pkg::SEL_OFF || sel_i[2]) begin
      state <= rpv_pkg::CHK_IDLE;
      run   <= '0;
      bad   <= '0;
    end else begin
      case (state)
        rpv_pkg::CHK_IDLE: begin
          state <= rpv_pkg::CHK_SEARCH;
        end
        rpv_pkg::CHK_SEARCH: begin
          if (miss) begin
            run <= '0;
          end else if (bit_valid_i) begin
            run <= run + 6'd1;
            if (run == rpv_pkg::LOCK_RUN - 6'd1) begin
              state <= rpv_pkg::CHK_LOCK;
              bad   <= '0;
            end
          end
        end
        rpv_pkg::CHK_LOCK: begin
          if (miss) begin
            bad <= bad + 3'd1;
            if (bad >= thr_i) begin
              state <= rpv_pkg::CHK_SEARCH;
              run   <= '0;
            end
          end else if (bit_valid_i) begin
            bad <= '0;
          end
        end
        default: state <= rpv_pkg::CHK_IDLE;
      endcase
    end
  end

  // Error pulse and sticky mismatch, cleared when the checker is turned off.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      err_o      <= 1'b0;
      mismatch_o <= 1'b0;
    end else begin
      err_o <= miss && state == rpv_pkg::CHK_LOCK;
      if (miss && state == rpv_pkg::CHK_LOCK) begin
        mismatch_o <= 1'b1;
      end else if (state == rpv_pkg::CHK_IDLE) begin
        mismatch_o <= 1'b0;
      end
    end
  end
  assign search_o = (state == rpv_pkg::CHK_SEARCH);

  // Timing pulse once per generator cycle of 2^order - 1 bits.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || sel_i == rpv_pkg::SEL_OFF) begin
      sync_cnt <= '0;
      sync_o   <= 1'b0;
    end else begin
      sync_o <= 1'b0;
      if (bit_valid_i) begin
        if (sync_cnt >= (31'h7fffffff >> (5'd31 - taps[9:5])) - 31'd1) begin
          sync_cnt <= '0;
          sync_o   <= 1'b1;
        end else begin
          sync_cnt <= sync_cnt + 31'd1;
        end
      end
    end
  end
endmodule

// ==== rpv_verifier.sv ====
`timescale 1ns/100ps
// Receive pattern verifier and error counter with its control registers.
module rpv_verifier (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Register port.
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Received lanes, one bit per lane per valid.
  input  wire logic [3:0] lane_bit_valid_i,
  input  wire logic [3:0] lane_bit_i,
  // Datapath error events per lane.
  input  wire logic [3:0] disparity_err_i,
  input  wire logic [3:0] fifo_err_i,
  input  wire logic [3:0] fifo_overflow_i,
  input  wire logic [3:0] fifo_underflow_i,
  // Lane alignment.
  input  wire logic       lane_align_done_i,
  // Flags.
  output logic      [3:0] live_lane_flag_o,
  output logic      [3:0] latched_lane_flag_o
);
  localparam int NL = rpv_pkg::NUM_LANES;
  localparam int CW = 30;  // Width of a lane's control word.
  localparam int CNT_WIDTH = rpv_pkg::CNT_W;  // Lane-0 error counter width.

  // Software registers.
  logic [3:0]  lane_control_load;       // Per-lane load bits.
  logic [7:0]  pattern_config;          // Length bit, length field, select.
  logic [7:0]  custom_pattern_low;
  logic [7:0]  custom_pattern_mid;
  logic [3:0]  custom_pattern_high;
  logic [2:0]  retain_threshold;
  logic        error_counter_clear;     // Self-clearing after one cycle.
  logic        latched_flag_clear;      // Self-clearing after one cycle.
  logic [2:0]  interrupt_source_sel;
  logic [3:0]  lane_datapath_check_en;
  logic [2:0]  datapath_source_sel;
  // Derived state.
  logic [19:0] custom_pattern_bits;
  logic [CW-1:0] ctl_word;
  logic [CW-1:0] lane_ctl [NL];
  logic [NL-1:0] pat_err, mismatch, searching, sync_pulse;
  logic [NL-1:0] dp_event, next_live;
  logic [CNT_WIDTH-1:0] bit_error_count;
  logic        clr_cnt_d;               // Previous clear bit, for edge detect.
  logic        clr_cnt_edge;
  logic [3:0]  sync_seen;               // Last timing pulse per lane.
  logic [7:0]  next_rdata;

  // Upper nibble only counts in 20-bit mode; otherwise it reads as zero here.
  assign custom_pattern_bits = {pattern_config[rpv_pkg::CFG_CP20_BIT] ?
                                custom_pattern_high : 4'h0,
                                custom_pattern_mid, custom_pattern_low};
  assign ctl_word = {retain_threshold, custom_pattern_bits,
                     pattern_config[rpv_pkg::CFG_CP20_BIT],
                     pattern_config[rpv_pkg::CFG_LEN_LSB +: 3],
                     pattern_config[rpv_pkg::CFG_SEL_LSB +: 3]};

  // Register writes.  Writing zero to a clear bit has no effect.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lane_control_load      <= '0;
      pattern_config         <= rpv_pkg::RESET_BYTE;
      custom_pattern_low     <= rpv_pkg::RESET_BYTE;
      custom_pattern_mid     <= rpv_pkg::RESET_BYTE;
      custom_pattern_high    <= '0;
      retain_threshold       <= '0;
      interrupt_source_sel   <= '0;
      lane_datapath_check_en <= '0;
      datapath_source_sel    <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        rpv_pkg::ADDR_LOAD:   lane_control_load <= reg_wdata_i[3:0];
        rpv_pkg::ADDR_CFG:    pattern_config <= {reg_wdata_i[7], 1'b0, reg_wdata_i[5:0]};
        rpv_pkg::ADDR_CP_LO:  custom_pattern_low <= reg_wdata_i;
        rpv_pkg::ADDR_CP_MID: custom_pattern_mid <= reg_wdata_i;
        rpv_pkg::ADDR_CP_HI:  custom_pattern_high <= reg_wdata_i[3:0];
        rpv_pkg::ADDR_THR:    retain_threshold <= reg_wdata_i[2:0];
        rpv_pkg::ADDR_CLRSEL: interrupt_source_sel <= reg_wdata_i[2:0];
        rpv_pkg::ADDR_DPCTL: begin
          lane_datapath_check_en <= reg_wdata_i[rpv_pkg::DP_EN_LSB +: 4];
          datapath_source_sel    <= reg_wdata_i[2:0];
        end
        default: ;  // Read-only or unmapped: ignored.
      endcase
    end
  end

  // Clear bits are set by software and dropped by hardware a cycle later.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      error_counter_clear <= 1'b0;
      latched_flag_clear  <= 1'b0;
      clr_cnt_d           <= 1'b0;
    end else begin
      clr_cnt_d <= error_counter_clear;
      error_counter_clear <= reg_wr_i && reg_addr_i == rpv_pkg::ADDR_CLRSEL &&
                             reg_wdata_i[rpv_pkg::CLR_CNT_BIT];
      latched_flag_clear  <= reg_wr_i && reg_addr_i == rpv_pkg::ADDR_CLRSEL &&
                             reg_wdata_i[rpv_pkg::CLR_FLAG_BIT];
    end
  end
  assign clr_cnt_edge = error_counter_clear && !clr_cnt_d;

  // One control latch and one checker per lane.
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      rpv_lane_latch #(.W(CW)) u_latch (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .load_i    (lane_control_load[g]),
        .d_i       (ctl_word),
        .q_o       (lane_ctl[g])
      );
      rpv_lane_check u_check (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .bit_valid_i (lane_bit_valid_i[g]),
        .bit_i       (lane_bit_i[g]),
        .sel_i       (lane_ctl[g][2:0]),
        .len_i       (lane_ctl[g][5:3]),
        .cp20_i      (lane_ctl[g][6]),
        .pattern_i   (lane_ctl[g][26:7]),
        .thr_i       (lane_ctl[g][29:27]),
        .err_o       (pat_err[g]),
        .mismatch_o  (mismatch[g]),
        .search_o    (searching[g]),
        .sync_o      (sync_pulse[g])
      );
      // Datapath event for this lane from the shared source select.
      always_comb begin
        case (datapath_source_sel)
          rpv_pkg::DP_DISP:  dp_event[g] = disparity_err_i[g];
          rpv_pkg::DP_FIFO:  dp_event[g] = fifo_err_i[g];
          rpv_pkg::DP_OVF:   dp_event[g] = fifo_overflow_i[g];
          rpv_pkg::DP_UNF:   dp_event[g] = fifo_underflow_i[g];
          rpv_pkg::DP_ALIGN: dp_event[g] = !lane_align_done_i;
          default:           dp_event[g] = 1'b0;  // Reserved codes report nothing.
        endcase
      end
      // Enabled datapath check wins; otherwise the chosen pattern source.
      always_comb begin
        if (lane_datapath_check_en[g]) begin
          next_live[g] = dp_event[g];
        end else begin
          case (interrupt_source_sel)
            rpv_pkg::IRQ_MISS:   next_live[g] = pat_err[g];
            rpv_pkg::IRQ_SEARCH: next_live[g] = searching[g];
            rpv_pkg::IRQ_SYNC:   next_live[g] = sync_pulse[g];
            default:             next_live[g] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Live flags follow their source one cycle later; latched ones stick.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      live_lane_flag_o    <= '0;
      latched_lane_flag_o <= '0;
      sync_seen           <= '0;
    end else begin
      live_lane_flag_o <= next_live;
      // A new event in the clearing cycle survives the clear.
      latched_lane_flag_o <= live_lane_flag_o |
                             (latched_flag_clear ? 4'h0 : latched_lane_flag_o);
      sync_seen <= sync_pulse;
    end
  end

  // Lane-0 error count saturates; the clear edge takes priority.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clr_cnt_edge) begin
      bit_error_count <= '0;
    end else if (next_live[0] && bit_error_count != '1) begin
      bit_error_count <= bit_error_count + CNT_WIDTH'(1);
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (reg_addr_i)
      rpv_pkg::ADDR_LOAD:   next_rdata = {sync_seen, lane_control_load};
      rpv_pkg::ADDR_STAT:   next_rdata = {mismatch, searching};
      rpv_pkg::ADDR_CFG:    next_rdata = pattern_config;
      rpv_pkg::ADDR_CP_LO:  next_rdata = custom_pattern_low;
      rpv_pkg::ADDR_CP_MID: next_rdata = custom_pattern_mid;
      rpv_pkg::ADDR_CP_HI:  next_rdata = {4'h0, custom_pattern_high};
      rpv_pkg::ADDR_THR:    next_rdata = {5'h00, retain_threshold};
      rpv_pkg::ADDR_CLRSEL: next_rdata = {lane_align_done_i, 2'h0, error_counter_clear,
                                          latched_flag_clear, interrupt_source_sel};
      rpv_pkg::ADDR_DPCTL:  next_rdata = {lane_datapath_check_en, 1'b0, datapath_source_sel};
      rpv_pkg::ADDR_FLAGS:  next_rdata = {latched_lane_flag_o, live_lane_flag_o};
      rpv_pkg::ADDR_CNT_LO: next_rdata = bit_error_count[7:0];
      default:              next_rdata = 8'h00;
    endcase
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_custom_upper_mask: assert property (
    !pattern_config[7] |-> custom_pattern_bits[19:16] == 4'h0) else $error("upper nibble used");
  chk_count_zeroed: assert property (
    clr_cnt_edge |=> bit_error_count == '0) else $error("counter not cleared");
  // A second clear write in the very next cycle legally keeps the bit up.
  chk_flag_clear_drops: assert property (
    latched_flag_clear && !(reg_wr_i && reg_addr_i == rpv_pkg::ADDR_CLRSEL &&
    reg_wdata_i[rpv_pkg::CLR_FLAG_BIT]) |=> !latched_flag_clear) else $error("clear bit stuck");
  chk_latched_follows: assert property (
    live_lane_flag_o[0] |=> latched_lane_flag_o[0]) else $error("latched flag missed");
  chk_latched_cleared: assert property (
    latched_flag_clear && live_lane_flag_o == 4'h0 |=> latched_lane_flag_o == 4'h0)
    else $error("latched flags not cleared");
  chk_flags_read: assert property (
    reg_rd_i && reg_addr_i == rpv_pkg::ADDR_FLAGS
    |=> reg_rdata_o == {$past(latched_lane_flag_o), $past(live_lane_flag_o)})
    else $error("flag read wrong");
  chk_align_read: assert property (
    reg_rd_i && reg_addr_i == rpv_pkg::ADDR_CLRSEL |=> reg_rdata_o[7] == $past(lane_align_done_i))
    else $error("align status wrong");
  chk_count_read: assert property (
    reg_rd_i && reg_addr_i == rpv_pkg::ADDR_CNT_LO |=> reg_rdata_o == $past(bit_error_count[7:0]))
    else $error("count read wrong");
  chk_ctl_hold: assert property (
    !lane_control_load[0] && $past(!lane_control_load[0]) |-> lane_ctl[0] == $past(lane_ctl[0]))
    else $error("control not held");
  chk_dp_source: assert property (
    lane_datapath_check_en[0] && datapath_source_sel == rpv_pkg::DP_DISP && disparity_err_i[0]
    |=> live_lane_flag_o[0]) else $error("datapath event lost");
  chk_count_step: assert property (
    next_live[0] && !clr_cnt_edge && bit_error_count != '1
    |=> bit_error_count == $past(bit_error_count) + CNT_WIDTH'(1)) else $error("count step");
  cov_lock_reached: cover property (searching[0] ##1 !searching[0] && lane_ctl[0][2:0] != 3'h0);
  cov_mismatch: cover property ($rose(mismatch[0]));
  cov_clear_race: cover property (latched_flag_clear && live_lane_flag_o[0]);
endmodule

// ==== rpv_tmds_src.sv ====
`timescale 1ns/100ps
// Source model: sends PRBS7 or a repeating word on all four lanes, one bit a cycle.
module rpv_tmds_src (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Run and single-bit corruption request.
  input  wire logic        run_i,
  input  wire logic        flip_i,
  // Word mode: repeat the low per_i bits of pat_i, bit 0 first.
  input  wire logic        prbs_i,
  input  wire logic [19:0] pat_i,
  input  wire logic [4:0]  per_i,
  // Lane outputs.
  output logic      [3:0]  valid_o,
  output logic      [3:0]  bit_o
);
  logic [6:0] sh; // Last seven PRBS7 bits, newest in bit 0.
  logic [4:0] ph; // Phase within the repeating word.
  logic       pb; // Next PRBS7 bit.
  logic       nb; // Next bit on the wire before any flip.
  assign pb = sh[6] ^ sh[5];
  assign nb = prbs_i ? pb : pat_i[ph];
  // The register keeps the true pattern, so a flip corrupts the wire only.
  // When stopped the data lines toggle, so a stale bit never looks valid.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sh      <= 7'h7f;
      ph      <= 5'h00;
      valid_o <= 4'h0;
      bit_o   <= 4'h0;
    end else if (run_i) begin
      // The generator keeps its own sequence, so word mode never spoils it.
      sh      <= {sh[5:0], pb};
      ph      <= (ph >= per_i - 5'h01) ? 5'h00 : ph + 5'h01;
      valid_o <= 4'hf;
      bit_o   <= {4{nb ^ flip_i}};
    end else begin
      valid_o <= 4'h0;
      bit_o   <= ~bit_o;
    end
  end
endmodule

// ==== tb_rx_pattern_verifier_bert.sv ====
`timescale 1ns/100ps
// Self-checking bench for the pattern verifier and its registers.
module tb_rx_pattern_verifier_bert;
  logic       clk_i, reset_n_i, wr, rd, align, run, flip; // Bench-driven controls.
  logic [7:0] addr, wdata, rdata;                          // Register port.
  logic [3:0] vld, lbit, live, latched;                    // Lanes and flags.
  logic [3:0] ev [4];                                      // Datapath event inputs.
  int         mismatches, cmp_count, cycles;               // Counters.
  logic        prbs;                                       // Partner sends PRBS7 when high.
  logic [19:0] pat;                                        // Partner word.
  logic [4:0]  per;                                        // Partner word length.

  rpv_verifier u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lane_bit_valid_i(vld), .lane_bit_i(lbit), .disparity_err_i(ev[0]),
    .fifo_err_i(ev[1]), .fifo_overflow_i(ev[2]), .fifo_underflow_i(ev[3]),
    .lane_align_done_i(align), .live_lane_flag_o(live), .latched_lane_flag_o(latched));
  rpv_tmds_src u_src (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run), .flip_i(flip),
    .prbs_i(prbs), .pat_i(pat), .per_i(per), .valid_o(vld), .bit_o(lbit));

  // Free-running 200 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard: the whole run needs about two thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask

  // Read data is registered at the read edge, so it is settled one half cycle on.
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    chk(rdata, exp);
  endtask

  // Every register reads zero after reset, unmapped places too.
  task automatic t_reset();
    for (int a = 8'h0e; a <= 8'h18; a++) rd_reg(8'(a), 8'h00);
    rd_reg(8'h30, 8'h00);
  endtask

  // Writable bits stick, reserved and read-only bits stay zero.
  task automatic t_regs();
    logic [7:0] a [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h15, 8'h0f};
    logic [7:0] e [10] = '{8'hbf, 8'ha5, 8'ha5, 8'h0f, 8'h07, 8'hf7, 8'h00, 8'h00, 8'h07, 8'h00};
    for (int i = 0; i < 10; i++) begin
      wr_reg(a[i], (i == 1 || i == 2) ? 8'ha5 : (i == 8) ? 8'h07 : 8'hff);
      rd_reg(a[i], e[i]);
    end
    for (int i = 0; i < 10; i++) wr_reg(a[i], 8'h00);
    align = 1'b1;
    rd_reg(8'h15, 8'h80);
  endtask

  // Each datapath source counts on lane 0 and raises the enabled lanes' flags.
  task automatic t_datapath();
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h15, 8'h08);
      wr_reg(8'h16, {4'h5, 1'b0, 3'(s)});
      ev[s] = 4'h5;
      repeat (s + 1) @(negedge clk_i);
      ev[s] = 4'h0;
      repeat (3) @(negedge clk_i);
      chk({4'h0, latched}, 8'h05);
    end
    wr_reg(8'h16, 8'h14);
    align = 1'b0;
    repeat (3) @(negedge clk_i);
    align = 1'b1;
    rd_reg(8'h18, 8'h0d);
    rd_reg(8'h17, 8'h50);
    wr_reg(8'h16, 8'h00);
    wr_reg(8'h15, 8'h10);
    rd_reg(8'h18, 8'h00);
    wr_reg(8'h15, 8'h08);
    rd_reg(8'h17, 8'h00);
    rd_reg(8'h15, 8'h80);
  endtask

  // PRBS7 lock, hold of latched controls, one corrupted bit, then turn-off.
  task automatic t_prbs();
    wr_reg(8'h15, 8'h01);
    wr_reg(8'h10, 8'h01);
    wr_reg(8'h0e, 8'h01);
    wr_reg(8'h0e, 8'h00);
    wr_reg(8'h10, 8'h00);
    run = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({4'h0, live}, 8'h01);
    rd_reg(8'h0f, 8'h01);
    for (int i = 0; i < 300 && live[0] !== 1'b0; i++) @(negedge clk_i);
    rd_reg(8'h0f, 8'h00);
    wr_reg(8'h15, 8'h18);
    wr_reg(8'h15, 8'h00);
    flip = 1'b1;
    @(negedge clk_i);
    flip = 1'b0;
    repeat (80) @(negedge clk_i);
    rd_reg(8'h18, 8'h01);
    rd_reg(8'h0f, 8'h10);
    rd_reg(8'h17, 8'h10);
    wr_reg(8'h0e, 8'h01);
    wr_reg(8'h0e, 8'h00);
    rd_reg(8'h0f, 8'h00);
    run = 1'b0;
  endtask

  // Pass lane 0 through the off state, which clears its mismatch, then hold cfg in it.
  task automatic load0(input logic [7:0] cfg);
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h0e, 8'h01);
    wr_reg(8'h10, cfg);
    wr_reg(8'h0e, 8'h00);
  endtask

  // Clock, 16-bit and 20-bit custom words each lock on lane 0 with no mismatch.
  task automatic t_words();
    logic [7:0]  c [3] = '{8'h02, 8'h03, 8'h83};
    logic [19:0] w [3] = '{20'h0001f, 20'hb963c, 20'hb963c};
    logic [4:0]  p [3] = '{5'h0a, 5'h10, 5'h14};
    wr_reg(8'h11, 8'h3c);
    wr_reg(8'h12, 8'h96);
    wr_reg(8'h13, 8'h0b);
    prbs = 1'b0;
    for (int m = 0; m < 3; m++) begin
      load0(c[m]);
      rd_reg(8'h0f, 8'h01);
      pat = w[m];
      per = p[m];
      run = 1'b1;
      repeat (500) @(negedge clk_i);
      run = 1'b0;
      rd_reg(8'h0f, 8'h00);
    end
    prbs = 1'b1;
  endtask

  // Timing-only mode at PRBS7 length: one pulse per 127 bits, counted on lane 0.
  task automatic t_timing();
    load0(8'h04);
    wr_reg(8'h15, 8'h12);
    run = 1'b1;
    repeat (200) @(negedge clk_i);
    run = 1'b0;
    rd_reg(8'h18, 8'h01);
    rd_reg(8'h0f, 8'h00);
  endtask

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: reset held three cycles, then each scenario in turn.
  initial begin
    {reset_n_i, wr, rd, align, run, flip} = 6'h00;
    {addr, wdata} = 16'h0000;
    ev = '{4'h0, 4'h0, 4'h0, 4'h0};
    {prbs, pat, per} = {1'b1, 20'h00000, 5'h0a};
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_regs();
    t_datapath();
    t_prbs();
    t_words();
    t_timing();
    final_report();
  end
endmodule
